// ### hdl/arf_pkg.sv
/*
  Shared constants and types for the converter result formatter and clock prescaler.
  Assumes a 32-bit AXI4-Lite register bus and a 10-bit converter core outside.
*/
package arf_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
  localparam logic [7:0] OFS_RESULT_LOW  = 8'h08;
  localparam logic [7:0] OFS_CLOCK_CFG   = 8'h0c;

  // ==========================================================
  // Status and control fields
  localparam int         SC_DONE_BIT     = 7;
  localparam int         SC_IRQEN_BIT    = 6;
  localparam int         SC_CONT_BIT     = 5;
  localparam int         SC_CHAN_LSB     = 0;
  localparam int         CHAN_W          = 5;
  localparam logic [4:0] CHAN_RESET      = 5'h1f;  // Converter powered off

  // ==========================================================
  // Clock configuration fields
  localparam int         CC_DIV_LSB      = 5;
  localparam int         CC_INSEL_BIT    = 4;
  localparam int         CC_MODE_LSB     = 2;
  localparam logic [2:0] DIV_RESET       = 3'h0;
  localparam logic       INSEL_RESET     = 1'b0;   // Oscillator clock

  // ==========================================================
  // Result layout modes
  typedef enum logic [1:0] {
    MODE_TRUNC  = 2'b00,
    MODE_RIGHT  = 2'b01,
    MODE_LEFT   = 2'b10,
    MODE_SIGNED = 2'b11
  } arf_mode_e;

  localparam arf_mode_e MODE_RESET = MODE_RIGHT;

  // ==========================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [2:0] div;
    logic       inSel;
    arf_mode_e  mode;
  } arf_clk_cfg_s;

  localparam arf_clk_cfg_s CFG_RESET = '{div: DIV_RESET, inSel: INSEL_RESET, mode: MODE_RESET};
endpackage

// ### hdl/arf_clk_div.sv
/*
  Converter clock prescaler: picks bus clock or oscillator tick, divides it.
  Assumes oscTick is a one-cycle enable synchronous to clk.
*/
`timescale 1ns/10ps
module arf_clk_div
  import arf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       oscTick,
  input  wire logic       inSel,
  input  wire logic [2:0] div,
  output logic            convClkTick
);
  // ==========================================================
  // Divide ratio minus one
  function automatic logic [3:0] ratioM1(input logic [2:0] d);
    case (d)
      3'h0:    ratioM1 = 4'h0;
      3'h1:    ratioM1 = 4'h1;
      3'h2:    ratioM1 = 4'h3;
      3'h3:    ratioM1 = 4'h7;
      default: ratioM1 = 4'hf;  // Top bit set divides by sixteen
    endcase
  endfunction

  logic       srcTick;
  logic [3:0] cnt_reg;

  // [RULE_12] source select mux
  assign srcTick = inSel ? 1'b1 : oscTick;

  // [RULE_10] count source ticks
  // Counter restarts cleanly if the ratio shrinks below the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg     <= 4'h0;
      convClkTick <= 1'b0;
    end else if (srcTick) begin
      if (cnt_reg >= ratioM1(div)) begin
        cnt_reg     <= 4'h0;
        convClkTick <= 1'b1;
      end else begin
        cnt_reg     <= cnt_reg + 4'h1;
        convClkTick <= 1'b0;
      end
    end else begin
      convClkTick <= 1'b0;
    end
  end

  chk_div_tick_cause: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    convClkTick |-> $past(srcTick) && ($past(cnt_reg) >= ratioM1($past(div))))
    else $error("prescaler tick without reaching the ratio");

  chk_bus_div1: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_12]
    (inSel && div == 3'h0) [*2] |=> convClkTick)
    else $error("bus clock divided by one must tick every cycle");
endmodule

// ### hdl/arf_result.sv
/*
  Result byte pair with justification layouts and the high-then-low read interlock.
  Assumes convDone is a one-cycle pulse with convResult valid in that cycle.
*/
`timescale 1ns/10ps
module arf_result
  import arf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  arf_mode_e       mode,
  input  wire logic       convDone,
  input  wire logic [9:0] convResult,
  input  wire logic       readHigh,
  input  wire logic       readLow,
  output logic [7:0]      highByte,
  output logic [7:0]      lowByte,
  output logic            lockActive
);
  // ==========================================================
  // Layouts of the pair
  logic [7:0] highNext;
  logic [7:0] lowNext;

  // [RULE_02] [RULE_06] [RULE_07] [RULE_08] layouts
  always_comb begin
    case (mode)
      MODE_TRUNC: begin
        highNext = 8'h00;
        lowNext  = convResult[9:2];
      end
      MODE_RIGHT: begin
        highNext = {6'h00, convResult[9:8]};
        lowNext  = convResult[7:0];
      end
      MODE_LEFT: begin
        highNext = convResult[9:2];
        lowNext  = {convResult[1:0], 6'h00};
      end
      default: begin  // Signed: top result bit inverted
        highNext = {~convResult[9], convResult[8:2]};
        lowNext  = {convResult[1:0], 6'h00};
      end
    endcase
  end

  // [RULE_04] interlock armed by high read
  // Truncation never arms it since the high byte is unused there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockActive <= 1'b0;
    end else if (readLow) begin
      lockActive <= 1'b0;  // [RULE_17] release on low read
    end else if (readHigh && mode != MODE_TRUNC) begin
      lockActive <= 1'b1;
    end
  end

  // [RULE_03] [RULE_05] [RULE_09] load or discard
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highByte <= 8'h00;
      lowByte  <= 8'h00;
    end else if (convDone && (mode == MODE_TRUNC || !lockActive)) begin
      highByte <= highNext;
      lowByte  <= lowNext;
    end
  end

  chk_low_frozen: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
    lockActive && mode != MODE_TRUNC |=> $stable(lowByte) && $stable(highByte))
    else $error("held result pair changed while interlocked");

  chk_left_layout: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    convDone && !lockActive && mode == MODE_LEFT
    |=> highByte == $past(convResult[9:2]) && lowByte == {$past(convResult[1:0]), 6'h00})
    else $error("left layout wrong");

  chk_trunc_load: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    convDone && mode == MODE_TRUNC |=> lowByte == $past(convResult[9:2]) && highByte == 8'h00)
    else $error("truncation load wrong");

  chk_release_load: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_17]
    readLow ##1 (convDone && mode == MODE_RIGHT && !readHigh)
    |=> lowByte == $past(convResult[7:0]))
    else $error("pair not reloaded after release");
endmodule

// ### hdl/arf_top.sv
/*
  Converter result formatter and clock selection, behind an AXI4-Lite slave.
  Assumes the analog core gives a one-cycle convDone with a 10-bit convResult,
  and oscTick marks oscillator clock edges synchronously to clk.
*/
// Functional notes
// [RULE_01] Unmapped channel codes give undefined results; nothing is guaranteed.
// [RULE_02] Left layout: high has eight top bits, low two bits at top.
// [RULE_03] Both bytes load on each finished conversion in two-byte modes.
// [RULE_04] Reading high byte freezes low byte until it is read.
// [RULE_05] While frozen, newly finished results are thrown away.
// [RULE_06] Right layout: high has two top bits low, low has eight bits.
// [RULE_07] Signed left layout inverts the result top bit.
// [RULE_08] Truncation: low byte has eight top bits, high reads zero.
// [RULE_09] Truncation updates low byte every conversion, no interlock.
// [RULE_10] Divide field: 000 by1, 001 by2, 010 by4, 011 by8, 1xx by16.
// [RULE_11] Software picks source and divider near the recommended converter rate.
// [RULE_12] Select bit set picks bus clock, clear oscillator; reset clears it.
// [RULE_13] Mode field 00 trunc, 01 right, 10 left, 11 signed; reset right.
// [RULE_14] A too slow converter clock is neither detected nor flagged.
// [RULE_15] Without interrupts, done flag holds until a result read.
// [RULE_16] With interrupts, request clears on result read or status write.
// [RULE_17] After the low read releases the hold, next result loads both.
`timescale 1ns/10ps
module arf_top
  import arf_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Converter core side
  input  wire logic              oscTick,
  input  wire logic              convDone,
  input  wire logic [9:0]        convResult,
  output logic [CHAN_W-1:0]      chanSel,
  output logic                   contMode,
  output logic                   convClkTick,
  output logic                   convIrq
);
  // ==========================================================
  // Address decode helper
  function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hitReg = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hitReg(a, OFS_STATUS_CTRL) || hitReg(a, OFS_RESULT_HIGH)
          || hitReg(a, OFS_RESULT_LOW) || hitReg(a, OFS_CLOCK_CFG);
  endfunction

  // ==========================================================
  // Declarations
  logic [ADDR_W-1:0] awAddr_reg;
  logic              awHeld_reg;
  logic [31:0]       wData_reg;
  logic              wStrb0_reg;
  logic              wHeld_reg;
  logic              wrFire;
  logic              rdFire;
  logic              scWrite;
  logic              cfgWrite;
  logic              readHigh;
  logic              readLow;
  logic              dataRead;
  logic              irqEn_reg;
  logic              done_reg;
  arf_clk_cfg_s      cfg_reg;
  logic [7:0]        highByte;
  logic [7:0]        lowByte;
  logic              lockActive;
  logic [7:0]        statusByte;
  logic [7:0]        rdByte;

  // ==========================================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign wrFire        = awHeld_reg && wHeld_reg && !s_axi_bvalid;

  // Address capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_reg <= 1'b0;
    end
  end

  // Data capture; only lane 0 carries register bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wHeld_reg  <= 1'b0;
      wData_reg  <= 32'h0000_0000;
      wStrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg  <= 1'b1;
      wData_reg  <= s_axi_wdata;
      wStrb0_reg <= s_axi_wstrb[0];
    end else if (wrFire) begin
      wHeld_reg <= 1'b0;
    end
  end

  // Write response one cycle after both halves are present
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign scWrite  = wrFire && wStrb0_reg && hitReg(awAddr_reg, OFS_STATUS_CTRL);
  assign cfgWrite = wrFire && wStrb0_reg && hitReg(awAddr_reg, OFS_CLOCK_CFG);

  // ==========================================================
  // Status and control register; done bit is not writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEn_reg <= 1'b0;
      contMode  <= 1'b0;
      chanSel   <= CHAN_RESET;
    end else if (scWrite) begin
      irqEn_reg <= wData_reg[SC_IRQEN_BIT];
      contMode  <= wData_reg[SC_CONT_BIT];
      chanSel   <= wData_reg[SC_CHAN_LSB +: CHAN_W];
    end
  end

  // [RULE_12] [RULE_13] clock and layout config
  // The bits above the fields read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RESET;
    end else if (cfgWrite) begin
      cfg_reg.div   <= wData_reg[CC_DIV_LSB +: 3];
      cfg_reg.inSel <= wData_reg[CC_INSEL_BIT];
      cfg_reg.mode  <= arf_mode_e'(wData_reg[CC_MODE_LSB +: 2]);
    end
  end

  // ==========================================================
  // Read channel: one outstanding read, side effects at address handshake
  assign s_axi_arready = !s_axi_rvalid;
  assign rdFire        = s_axi_arvalid && s_axi_arready;
  assign readHigh      = rdFire && hitReg(s_axi_araddr, OFS_RESULT_HIGH);
  assign readLow       = rdFire && hitReg(s_axi_araddr, OFS_RESULT_LOW);
  assign dataRead      = readHigh || readLow;

  // Interrupt mode always reads the done bit as zero
  assign statusByte = {done_reg && !irqEn_reg, irqEn_reg, contMode, chanSel};

  // Read data selection
  always_comb begin
    if (hitReg(s_axi_araddr, OFS_STATUS_CTRL)) begin
      rdByte = statusByte;
    end else if (hitReg(s_axi_araddr, OFS_RESULT_HIGH)) begin
      rdByte = highByte;
    end else if (hitReg(s_axi_araddr, OFS_RESULT_LOW)) begin
      rdByte = lowByte;
    end else if (hitReg(s_axi_araddr, OFS_CLOCK_CFG)) begin
      rdByte = {cfg_reg.div, cfg_reg.inSel, cfg_reg.mode, 2'b00};
    end else begin
      rdByte = 8'h00;
    end
  end

  // Read data registered; unmapped reads answer zero with an error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rdByte};
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Completion flag and request
  // [RULE_15] done flag sticky until read
  // A finishing conversion wins over a clearing read in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else if (convDone && !irqEn_reg) begin
      done_reg <= 1'b1;
    end else if (dataRead) begin
      done_reg <= 1'b0;
    end
  end

  // [RULE_16] request cleared by read or write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convIrq <= 1'b0;
    end else if (convDone && irqEn_reg) begin
      convIrq <= 1'b1;
    end else if (dataRead || scWrite) begin
      convIrq <= 1'b0;
    end
  end

  // ==========================================================
  // Submodules
  // [RULE_01] [RULE_14] results passed on as given, no rate check
  arf_result u_result (
    .clk        (clk),
    .rst_n      (rst_n),
    .mode       (cfg_reg.mode),
    .convDone   (convDone),
    .convResult (convResult),
    .readHigh   (readHigh),
    .readLow    (readLow),
    .highByte   (highByte),
    .lowByte    (lowByte),
    .lockActive (lockActive)
  );

  arf_clk_div u_clk_div (
    .clk         (clk),
    .rst_n       (rst_n),
    .oscTick     (oscTick),
    .inSel       (cfg_reg.inSel),
    .div         (cfg_reg.div),
    .convClkTick (convClkTick)
  );

  // ==========================================================
  // Checks
  chk_done_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
    convDone && !irqEn_reg |=> done_reg)
    else $error("done flag not set by conversion");

  chk_done_holds: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
    done_reg && !dataRead |=> done_reg)
    else $error("done flag dropped without a result read");

  chk_irq_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
    convIrq && (dataRead || scWrite) && !convDone |=> !convIrq)
    else $error("request not cleared by read or write");

  chk_irq_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
    convDone && irqEn_reg |=> convIrq ##0 !statusByte[7])
    else $error("request not raised or done bit visible in interrupt mode");

  chk_high_read_lock: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
    readHigh && cfg_reg.mode != MODE_TRUNC ##1 (convDone && !readLow)
    |=> $stable(lowByte))
    else $error("result not discarded while held");

  chk_right_layout: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
    convDone && !lockActive && cfg_reg.mode == MODE_RIGHT
    |=> highByte == {6'h00, $past(convResult[9:8])} && lowByte == $past(convResult[7:0]))
    else $error("right layout wrong");

  chk_signed_layout: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
    convDone && !lockActive && cfg_reg.mode == MODE_SIGNED
    |=> highByte[7] == !$past(convResult[9]))
    else $error("signed layout top bit not inverted");

  // The config lands with the response, so only the cycle after it must be quiet
  chk_write_resp: assert property (@(posedge clk) disable iff (!rst_n)
    wrFire |=> s_axi_bvalid ##1 $stable(cfg_reg))
    else $error("write response missing");
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench for the converter result formatter and clock prescaler.
  Assumes arf_pkg and arf_top are compiled first; the bench is the bus master and converter core.
*/
`timescale 1ns/10ps
module tb_top;
  import arf_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        oscTick;
  logic [1:0]  oscCnt;
  logic        convDone;
  logic [9:0]  convResult;
  logic [4:0]  chanSel;
  logic        contMode;
  logic        convClkTick;
  logic        convIrq;
  int          errTotal;
  int          numChecks;

`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin errTotal++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

  arf_top #(.ADDR_W(8)) arf_top_i (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .oscTick(oscTick), .convDone(convDone),
    .convResult(convResult), .chanSel(chanSel), .contMode(contMode),
    .convClkTick(convClkTick), .convIrq(convIrq)
  );

  // ==========================================================
  // Clock, reset and oscillator tick (one pulse every 3 cycles)
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // One driver for the tick counter; reset gives it a known phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscCnt <= 2'd0;
      oscTick <= 1'b0;
    end else begin
      oscCnt <= (oscCnt == 2'd2) ? 2'd0 : oscCnt + 2'd1;
      oscTick <= (oscCnt == 2'd2);
    end
  end

  // ==========================================================
  // Bus master tasks; ready lines are held high so answers are taken at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask

  // One finished conversion, a single-cycle pulse
  task automatic conv(input logic [9:0] v);
    convResult <= v;
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    // oscillator and right mode after reset
    rd(OFS_CLOCK_CFG, d, r);
    `CHK("clock cfg", 32'h04, d)
    rd(OFS_STATUS_CTRL, d, r);
    `CHK("status", 32'h1f, d)
    `CHK("chanSel", 5'h1f, chanSel)
  endtask

  task automatic t_layout();
    arf_mode_e   m;
    logic [9:0]  v;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  eh;
    logic [7:0]  el;
    for (int i = 0; i < 8; i++) begin
      m = arf_mode_e'(i[1:0]);
      v = (i < 4) ? 10'h2a5 : 10'h15a;
      eh = {v[9] ^ (m == MODE_SIGNED), v[8:2]};
      el = {v[1:0], 6'h00};
      if (m == MODE_TRUNC) begin
        eh = 8'h00;
        el = v[9:2];
      end
      if (m == MODE_RIGHT) begin
        eh = {6'h00, v[9:8]};
        el = v[7:0];
      end
      wr(OFS_CLOCK_CFG, {24'h0, 3'h0, 1'b0, m, 2'b00}, r);
      conv(v);
      rd(OFS_RESULT_HIGH, d, r);
      `CHK("high byte", {24'h0, eh}, d)
      rd(OFS_RESULT_LOW, d, r);
      `CHK("low byte", {24'h0, el}, d)
    end
  endtask

  task automatic t_lock();
    logic [31:0] d;
    logic [1:0]  r;
    // hold after high read, then release
    wr(OFS_CLOCK_CFG, 32'h04, r);
    conv(10'h1c3);
    rd(OFS_RESULT_HIGH, d, r);
    conv(10'h2e7);
    rd(OFS_RESULT_LOW, d, r);
    `CHK("held low", 32'hc3, d)
    rd(OFS_RESULT_HIGH, d, r);
    `CHK("kept high", 32'h01, d)
    rd(OFS_RESULT_LOW, d, r);
    conv(10'h33c);
    rd(OFS_RESULT_HIGH, d, r);
    `CHK("new high", 32'h03, d)
    rd(OFS_RESULT_LOW, d, r);
    `CHK("new low", 32'h3c, d)
    wr(OFS_CLOCK_CFG, 32'h00, r);
    conv(10'h0ff);
    rd(OFS_RESULT_HIGH, d, r);
    conv(10'h3f0);
    rd(OFS_RESULT_LOW, d, r);
    `CHK("trunc low", 32'hfc, d)
  endtask

  task automatic t_div();
    logic [1:0] r;
    int         gap;
    int         exp;
    // ratio per code, bus clock then oscillator
    for (int i = 0; i < 10; i++) begin
      exp = (i < 8) ? (1 << ((i > 4) ? 4 : i)) : 3 * (i - 7);
      wr(OFS_CLOCK_CFG, {24'h0, i[2:0], (i < 8), 4'b0100}, r);
      repeat (40) @(posedge clk);
      do @(posedge clk); while (convClkTick !== 1'b1);
      gap = 0;
      do begin
        @(posedge clk);
        gap++;
      end while (convClkTick !== 1'b1 && gap < 100);
      `CHK("tick gap", exp, gap)
    end
  endtask

  task automatic t_flag();
    logic [31:0] d;
    logic [1:0]  r;
    // done flag stays until a result read
    wr(OFS_CLOCK_CFG, 32'h04, r);
    // Interrupts off: continuous bit and channel 5 only
    wr(OFS_STATUS_CTRL, 32'h25, r);
    `CHK("chanSel", 5'h05, chanSel)
    `CHK("contMode", 1'b1, contMode)
    conv(10'h011);
    repeat (5) @(posedge clk);
    rd(OFS_STATUS_CTRL, d, r);
    `CHK("done set", 32'ha5, d)
    rd(OFS_RESULT_HIGH, d, r);
    rd(OFS_RESULT_LOW, d, r);
    rd(OFS_STATUS_CTRL, d, r);
    `CHK("done clear", 32'h25, d)
    // request cleared by result read or status write
    wr(OFS_STATUS_CTRL, 32'h5f, r);
    conv(10'h022);
    `CHK("irq set", 1'b1, convIrq)
    rd(OFS_RESULT_HIGH, d, r);
    `CHK("irq rd clr", 1'b0, convIrq)
    rd(OFS_RESULT_LOW, d, r);
    conv(10'h033);
    wr(OFS_STATUS_CTRL, 32'h5f, r);
    @(posedge clk);
    `CHK("irq wr clr", 1'b0, convIrq)
  endtask

  task automatic t_map();
    logic [31:0] d;
    logic [1:0]  r;
    // unmapped place refused, result byte read-only
    wr(8'h10, 32'hff, r);
    `CHK("wr resp", RESP_SLVERR, r)
    rd(8'h10, d, r);
    `CHK("rd resp", RESP_SLVERR, r)
    wr(OFS_RESULT_LOW, 32'h5a, r);
    `CHK("ro resp", RESP_OKAY, r)
    // Low byte still holds the last right-mode load of 10'h033
    rd(OFS_RESULT_LOW, d, r);
    `CHK("ro low", 32'h33, d)
  endtask

  // ==========================================================
  // Verdict and main sequence
  task automatic complete_run();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    convDone = 1'b0;
    convResult = 10'h000;
    errTotal = 0;
    numChecks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_layout();
    t_lock();
    t_div();
    t_flag();
    t_map();
    complete_run();
  end

  // Watchdog: the run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    complete_run();
  end
endmodule
